// *** rtl/bit_op_pkg.sv ***
// package of encodings and timing figures for the single-bit instruction decoder
// assumes a 5-bit operand field, 4-bit condition field and one size bit from the fetch stage
package bit_op_pkg;
    // ==========================================================
    // operation selector
    typedef enum logic [3:0] {
        OP_NONE, OP_AND, OP_NAND, OP_NOR, OP_XNOR, OP_OR,
        OP_CLEAR, OP_INVERT, OP_NTEST, OP_INDEX, OP_CBS_MEM, OP_CBS_CARRY
    } bit_op_t;

    // operand kinds
    typedef enum logic [3:0] {
        K_DREG, K_AREG, K_IND, K_REL11_AN, K_REL11_SF, K_REL19_AN, K_REL19_SF,
        K_REL27_AN, K_ABS19, K_ABS27, K_BAD
    } opnd_kind_t;

    // ==========================================================
    // operand field codes
    localparam logic [4:0] F_REG0_LOW = 5'h12;
    localparam logic [4:0] F_REG0_HIGH = 5'h10;
    localparam logic [4:0] F_REG1_LOW = 5'h13;
    localparam logic [4:0] F_REG1_HIGH = 5'h11;
    localparam logic [4:0] F_ADDR0 = 5'h02;
    localparam logic [4:0] F_ADDR1 = 5'h03;
    localparam logic [4:0] F_IND_ADDR0 = 5'h00;
    localparam logic [4:0] F_IND_ADDR1 = 5'h01;
    localparam logic [4:0] F_B11_ADDR0 = 5'h04;
    localparam logic [4:0] F_B11_ADDR1 = 5'h05;
    localparam logic [4:0] F_B11_STATIC = 5'h06;
    localparam logic [4:0] F_B11_FRAME = 5'h07;
    localparam logic [4:0] F_B19_ADDR0 = 5'h08;
    localparam logic [4:0] F_B19_ADDR1 = 5'h09;
    localparam logic [4:0] F_B19_STATIC = 5'h0A;
    localparam logic [4:0] F_B19_FRAME = 5'h0B;
    localparam logic [4:0] F_B27_ADDR0 = 5'h0C;
    localparam logic [4:0] F_B27_ADDR1 = 5'h0D;
    localparam logic [4:0] F_ABS27 = 5'h0E;
    localparam logic [4:0] F_ABS19 = 5'h0F;

    // condition codes
    localparam logic [3:0] C_UNSIGNED_BELOW = 4'h0;
    localparam logic [3:0] C_UNSIGNED_NOT_ABOVE = 4'h1;
    localparam logic [3:0] C_NOT_EQUAL = 4'h2;
    localparam logic [3:0] C_NON_NEGATIVE = 4'h3;
    localparam logic [3:0] C_NO_OVERFLOW = 4'h4;
    localparam logic [3:0] C_SIGNED_GT = 4'h5;
    localparam logic [3:0] C_SIGNED_GE = 4'h6;
    localparam logic [3:0] C_UNSIGNED_AT_OR_ABOVE = 4'h8;
    localparam logic [3:0] C_UNSIGNED_ABOVE = 4'h9;
    localparam logic [3:0] C_EQUAL = 4'hA;
    localparam logic [3:0] C_NEGATIVE = 4'hB;
    localparam logic [3:0] C_OVERFLOW = 4'hC;
    localparam logic [3:0] C_SIGNED_LE = 4'hD;
    localparam logic [3:0] C_SIGNED_LT = 4'hE;

    // size bit
    localparam logic SIZE_BYTE = 1'b0;
    localparam logic SIZE_WORD = 1'b1;

    // ==========================================================
    // cycle and byte figures
    localparam logic [3:0] CYC_COMB_REG = 4'h2;
    localparam logic [3:0] CYC_COMB_MEM = 4'h4;
    localparam logic [3:0] CYC_SIMPLE_REG = 4'h1;
    localparam logic [3:0] CYC_SIMPLE_MEM = 4'h3;
    localparam logic [3:0] CYC_INDEX_REG = 4'h4;
    localparam logic [3:0] CYC_INDEX_MEM = 4'h6;
    localparam logic [3:0] CYC_INDEX_DSP8_AN = 4'h3;
    localparam logic [3:0] CYC_CBS_REG = 4'h3;
    localparam logic [3:0] CYC_CBS_MEM = 4'h4;
    localparam logic [3:0] CYC_CBS_CARRY = 4'h2;
    localparam logic [3:0] BYTES_CBS_CARRY = 4'h2;
    localparam logic [3:0] BYTES_COMB_BASE = 4'h3;
    localparam logic [3:0] BYTES_SIMPLE_BASE = 4'h2;
    localparam logic [3:0] BYTES_CBS_BASE = 4'h3;
    localparam logic [3:0] BYTES_INDEX_BASE = 4'h2;
    localparam logic [3:0] CYC_INDEX_PENALTY = 4'h1;
endpackage : bit_op_pkg

// *** rtl/bit_op_instruction_decoder.sv ***
// decoder and cycle-timing logic for single-bit instructions
// assumes the fetch stage presents one decoded instruction per valid pulse
// and the flag register supplies the condition flags and carry
`timescale 1ns/1ps
`default_nettype none

module bit_op_instruction_decoder
    import bit_op_pkg::*;
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic instr_valid,
    input wire bit_op_t instr_op,
    input wire logic [4:0] opnd_field,
    input wire logic size_bit,
    input wire logic cond_upper,
    input wire logic [2:0] cond_low,
    input wire logic operand_bit,
    input wire logic carry_in,
    input wire logic zero_in,
    input wire logic sign_in,
    input wire logic ovf_in,
    output logic dec_valid,
    output opnd_kind_t opnd_kind,
    output logic [1:0] reg_sel,
    output logic size_word,
    output logic [3:0] instr_bytes,
    output logic [3:0] instr_cycles,
    output logic carry_we,
    output logic carry_out,
    output logic bit_we,
    output logic bit_out
);

    // ==========================================================
    // decode helpers
    // operand field to kind; register byte index kept separately
    function automatic opnd_kind_t kind_of(input logic [4:0] f);
        case (f)
            F_REG0_LOW, F_REG0_HIGH, F_REG1_LOW, F_REG1_HIGH: kind_of = K_DREG;
            F_ADDR0, F_ADDR1: kind_of = K_AREG;
            F_IND_ADDR0, F_IND_ADDR1: kind_of = K_IND;
            F_B11_ADDR0, F_B11_ADDR1: kind_of = K_REL11_AN;
            F_B11_STATIC, F_B11_FRAME: kind_of = K_REL11_SF;
            F_B19_ADDR0, F_B19_ADDR1: kind_of = K_REL19_AN;
            F_B19_STATIC, F_B19_FRAME: kind_of = K_REL19_SF;
            F_ABS19: kind_of = K_ABS19;
            F_B27_ADDR0, F_B27_ADDR1: kind_of = K_REL27_AN;
            F_ABS27: kind_of = K_ABS27;
            default: kind_of = K_BAD;
        endcase
    endfunction : kind_of

    // extra operand bytes beyond the base length
    function automatic logic [3:0] ext_bytes(input opnd_kind_t k);
        case (k)
            K_REL11_AN, K_REL11_SF: ext_bytes = 4'h1;
            K_REL19_AN, K_REL19_SF, K_ABS19: ext_bytes = 4'h2;
            K_REL27_AN, K_ABS27: ext_bytes = 4'h3;
            default: ext_bytes = 4'h0;
        endcase
    endfunction : ext_bytes

    // condition evaluation; upper bit inverts the lower sense
    function automatic logic cond_true(input logic [3:0] c, input logic cf, input logic zf,
                                       input logic sf, input logic of);
        logic base;
        base = 1'b0;
        case (c[2:0])
            C_UNSIGNED_BELOW[2:0]: base = !cf;
            C_UNSIGNED_NOT_ABOVE[2:0]: base = !(cf && !zf);
            C_NOT_EQUAL[2:0]: base = !zf;
            C_NON_NEGATIVE[2:0]: base = !sf;
            C_NO_OVERFLOW[2:0]: base = !of;
            C_SIGNED_GT[2:0]: base = !((sf ^ of) || zf);
            C_SIGNED_GE[2:0]: base = !(sf ^ of);
            default: base = 1'b0;
        endcase
        cond_true = c[3] ^ base;
    endfunction : cond_true

    // ==========================================================
    // combinational decode
    opnd_kind_t kind_w;
    logic is_reg_w;
    logic [3:0] cond_w;
    logic cond_hit_w;
    logic index_pend_r;
    logic index_pend_nxt;
    logic dec_valid_nxt, carry_we_nxt, carry_out_nxt, bit_we_nxt, bit_out_nxt, size_word_nxt;
    opnd_kind_t kind_nxt;
    logic [1:0] reg_sel_nxt;
    logic [3:0] bytes_nxt, cycles_nxt;

    assign kind_w = kind_of(opnd_field);
    assign is_reg_w = (kind_w == K_DREG) || (kind_w == K_AREG);
    assign cond_w = {cond_upper, cond_low};
    assign cond_hit_w = cond_true(cond_w, carry_in, zero_in, sign_in, ovf_in);

    // next values for the decoded result and prefix tracking
    always_comb begin
        dec_valid_nxt = instr_valid;
        kind_nxt = kind_w;
        reg_sel_nxt = {opnd_field[0], !opnd_field[1]}; // bit0 high byte, bit1 reg1
        size_word_nxt = (instr_op == OP_INDEX) && (size_bit == SIZE_WORD);
        bytes_nxt = 4'h0;
        cycles_nxt = 4'h0;
        carry_we_nxt = 1'b0;
        carry_out_nxt = carry_in;
        bit_we_nxt = 1'b0;
        bit_out_nxt = operand_bit;
        index_pend_nxt = index_pend_r;
        if (instr_valid) begin
            index_pend_nxt = (instr_op == OP_INDEX);
            case (instr_op)
                OP_AND, OP_NAND, OP_NOR, OP_XNOR, OP_OR: begin
                    bytes_nxt = BYTES_COMB_BASE + ext_bytes(kind_w);
                    cycles_nxt = is_reg_w ? CYC_COMB_REG : CYC_COMB_MEM;
                    carry_we_nxt = 1'b1;
                    case (instr_op)
                        OP_AND: carry_out_nxt = carry_in & operand_bit;
                        OP_NAND: carry_out_nxt = carry_in & !operand_bit;
                        OP_NOR: carry_out_nxt = carry_in | !operand_bit;
                        OP_XNOR: carry_out_nxt = !(carry_in ^ operand_bit);
                        default: carry_out_nxt = carry_in | operand_bit;
                    endcase
                end
                OP_CLEAR, OP_INVERT, OP_NTEST: begin
                    bytes_nxt = BYTES_SIMPLE_BASE + ext_bytes(kind_w);
                    cycles_nxt = is_reg_w ? CYC_SIMPLE_REG : CYC_SIMPLE_MEM;
                    bit_we_nxt = (instr_op != OP_NTEST);
                    bit_out_nxt = (instr_op == OP_CLEAR) ? 1'b0 : !operand_bit;
                    carry_we_nxt = (instr_op == OP_NTEST);
                    carry_out_nxt = (instr_op == OP_NTEST) ? !operand_bit : carry_in;
                end
                OP_INDEX: begin
                    // general operand encoding: low nibble codes shift length by one byte set
                    bytes_nxt = BYTES_INDEX_BASE + ext_bytes(kind_w);
                    if (is_reg_w)
                        cycles_nxt = CYC_INDEX_REG;
                    else if (kind_w == K_REL11_AN)
                        cycles_nxt = CYC_INDEX_DSP8_AN;
                    else
                        cycles_nxt = CYC_INDEX_MEM;
                end
                OP_CBS_MEM: begin
                    bytes_nxt = BYTES_CBS_BASE + ext_bytes(kind_w);
                    // an address register bit is a register operand here too, not a memory access
                    cycles_nxt = is_reg_w ? CYC_CBS_REG : CYC_CBS_MEM;
                    bit_we_nxt = 1'b1;
                    bit_out_nxt = cond_hit_w;
                end
                OP_CBS_CARRY: begin
                    bytes_nxt = BYTES_CBS_CARRY;
                    cycles_nxt = CYC_CBS_CARRY;
                    carry_we_nxt = 1'b1;
                    carry_out_nxt = cond_hit_w;
                end
                default: begin
                    bytes_nxt = 4'h0;
                end
            endcase
            if (index_pend_r)
                cycles_nxt = cycles_nxt + CYC_INDEX_PENALTY;
        end
    end

    // registered result
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            dec_valid <= 1'b0;
            opnd_kind <= K_DREG;
            reg_sel <= 2'b00;
            size_word <= 1'b0;
            instr_bytes <= 4'h0;
            instr_cycles <= 4'h0;
            carry_we <= 1'b0;
            carry_out <= 1'b0;
            bit_we <= 1'b0;
            bit_out <= 1'b0;
            index_pend_r <= 1'b0;
        end else begin
            dec_valid <= dec_valid_nxt;
            opnd_kind <= kind_nxt;
            reg_sel <= reg_sel_nxt;
            size_word <= size_word_nxt;
            instr_bytes <= bytes_nxt;
            instr_cycles <= cycles_nxt;
            carry_we <= carry_we_nxt;
            carry_out <= carry_out_nxt;
            bit_we <= bit_we_nxt;
            bit_out <= bit_out_nxt;
            index_pend_r <= index_pend_nxt;
        end
    end

    // ==========================================================
    // checks
    property p_comb_reg_cycles;
        @(posedge core_clk) disable iff (!arst_n)
        (instr_valid && instr_op == OP_AND && kind_w == K_DREG && !index_pend_r) |=> (instr_cycles == 4'h2);
    endproperty
    a_comb_reg_cycles: assert property (p_comb_reg_cycles) else $error("combine register cycles wrong");

    property p_simple_mem_cycles;
        @(posedge core_clk) disable iff (!arst_n)
        (instr_valid && instr_op == OP_CLEAR && kind_w == K_IND && !index_pend_r) |=> (instr_cycles == 4'h3);
    endproperty
    a_simple_mem_cycles: assert property (p_simple_mem_cycles) else $error("clear memory cycles wrong");

    property p_index_penalty;
        @(posedge core_clk) disable iff (!arst_n)
        (instr_valid && instr_op == OP_CLEAR && kind_w == K_DREG && index_pend_r) |=> (instr_cycles == 4'h2);
    endproperty
    a_index_penalty: assert property (p_index_penalty) else $error("index penalty missing");

    property p_index_dsp8;
        @(posedge core_clk) disable iff (!arst_n)
        (instr_valid && instr_op == OP_INDEX && opnd_field == 5'h04 && !index_pend_r) |=> (instr_cycles == 4'h3);
    endproperty
    a_index_dsp8: assert property (p_index_dsp8) else $error("index dsp8 cycles wrong");

    property p_carry_form;
        @(posedge core_clk) disable iff (!arst_n)
        (instr_valid && instr_op == OP_CBS_CARRY && !index_pend_r) |=> (instr_bytes == 4'h2 && instr_cycles == 4'h2);
    endproperty
    a_carry_form: assert property (p_carry_form) else $error("carry form length wrong");

    property p_cbs_equal;
        @(posedge core_clk) disable iff (!arst_n)
        (instr_valid && instr_op == OP_CBS_MEM && cond_upper && cond_low == 3'h2) |=> (bit_we && bit_out == $past(zero_in));
    endproperty
    a_cbs_equal: assert property (p_cbs_equal) else $error("equal condition store wrong");

    property p_and_carry;
        @(posedge core_clk) disable iff (!arst_n)
        (instr_valid && instr_op == OP_AND) |=> (carry_we && !bit_we && carry_out == ($past(carry_in) & $past(operand_bit)));
    endproperty
    a_and_carry: assert property (p_and_carry) else $error("and carry result wrong");

    property p_reg_kind;
        @(posedge core_clk) disable iff (!arst_n)
        (instr_valid && opnd_field == 5'h10) |=> (opnd_kind == K_DREG && reg_sel == 2'b01);
    endproperty
    a_reg_kind: assert property (p_reg_kind) else $error("reg0 high decode wrong");

    property p_abs27;
        @(posedge core_clk) disable iff (!arst_n)
        (instr_valid && opnd_field == 5'h0E) |=> (opnd_kind == K_ABS27);
    endproperty
    a_abs27: assert property (p_abs27) else $error("absolute 27 decode wrong");

endmodule : bit_op_instruction_decoder
`default_nettype wire

// *** tb/flag_model.sv ***
// carry flag holder standing in for the execution pipeline
// assumes the decoder's carry write strobe stands for one core_clk cycle
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// carry register fed back to the decoder
module flag_model (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic carry_we,
    input wire logic carry_out,
    output logic carry_in
);
    logic carry_r;
    logic carry_nxt;
    // keep old carry unless a write is strobed
    always_comb begin
        carry_nxt = carry_we ? carry_out : carry_r;
    end
    // registered, so a write shows one cycle after the strobe
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            carry_r <= 1'b0;
        end else begin
            carry_r <= carry_nxt;
        end
    end
    assign carry_in = carry_r;
endmodule : flag_model
`default_nettype wire

// *** tb/tb.sv ***
// self-checking bench for the single-bit instruction decoder
// assumes one-cycle answer latency and a carry fed back by flag_model
`timescale 1ns/1ps
`default_nettype none
module tb;
    import bit_op_pkg::*;
    logic core_clk = 1'b0, arst_n = 1'b0, instr_valid = 1'b0, size_bit = 1'b0;
    bit_op_t instr_op = OP_NONE;
    logic [4:0] opnd_field = 5'h00;
    logic cond_upper = 1'b0, operand_bit = 1'b0, zero_in = 1'b0, sign_in = 1'b0, ovf_in = 1'b0;
    logic [2:0] cond_low = 3'h0;
    logic carry_in, dec_valid, size_word, carry_we, carry_out, bit_we, bit_out;
    opnd_kind_t opnd_kind;
    logic [1:0] reg_sel;
    logic [3:0] instr_bytes, instr_cycles;
    int err_total = 0, samples_checked = 0, cyc_cnt = 0;
    logic sz = 1'b0, ce, ex;
    logic [4:0] ft [20] = '{5'h12, 5'h10, 5'h13, 5'h11, 5'h02, 5'h03, 5'h00, 5'h01, 5'h04, 5'h05,
        5'h06, 5'h07, 5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h0E, 5'h0F};
    opnd_kind_t kt [20] = '{K_DREG, K_DREG, K_DREG, K_DREG, K_AREG, K_AREG, K_IND, K_IND,
        K_REL11_AN, K_REL11_AN, K_REL11_SF, K_REL11_SF, K_REL19_AN, K_REL19_AN, K_REL19_SF,
        K_REL19_SF, K_REL27_AN, K_REL27_AN, K_ABS27, K_ABS19};
    // ==========================================================
    // clock and instances
    initial begin
        forever #5 core_clk = ~core_clk;
    end
    bit_op_instruction_decoder i_bit_op_instruction_decoder (.core_clk(core_clk), .arst_n(arst_n),
        .instr_valid(instr_valid), .instr_op(instr_op), .opnd_field(opnd_field), .size_bit(size_bit),
        .cond_upper(cond_upper), .cond_low(cond_low), .operand_bit(operand_bit), .carry_in(carry_in),
        .zero_in(zero_in), .sign_in(sign_in), .ovf_in(ovf_in), .dec_valid(dec_valid),
        .opnd_kind(opnd_kind), .reg_sel(reg_sel), .size_word(size_word), .instr_bytes(instr_bytes),
        .instr_cycles(instr_cycles), .carry_we(carry_we), .carry_out(carry_out), .bit_we(bit_we),
        .bit_out(bit_out));
    flag_model i_flag_model (.core_clk(core_clk), .arst_n(arst_n), .carry_we(carry_we),
        .carry_out(carry_out), .carry_in(carry_in));
    // ==========================================================
    // shared tasks
    task automatic chk(string n, logic [7:0] s, logic [7:0] e);
        samples_checked++;
        if (s !== e) begin
            err_total++;
            $display("Error %s expected %0h seen %0h", n, e, s);
        end
    endtask : chk
    // one valid cycle, then idle; answer is read after the following edge
    task automatic drv(bit_op_t op, logic [4:0] f, logic b, logic [3:0] cc);
        @(posedge core_clk);
        instr_valid <= 1'b1;
        instr_op <= op;
        opnd_field <= f;
        operand_bit <= b;
        size_bit <= sz;
        {cond_upper, cond_low} <= cc;
        @(posedge core_clk);
        instr_valid <= 1'b0;
        #1;
    endtask : drv
    function automatic int ext(opnd_kind_t k);
        case (k)
            K_REL11_AN, K_REL11_SF: return 1;
            K_REL19_AN, K_REL19_SF, K_ABS19: return 2;
            K_REL27_AN, K_ABS27: return 3;
            default: return 0;
        endcase
    endfunction : ext
    // lower bits pick the base test, upper bit inverts it
    function automatic logic cond_f(logic [3:0] cc, logic c, logic z, logic s, logic o);
        logic r;
        case (cc[2:0])
            3'h0: r = !c;
            3'h1: r = !c | z;
            3'h2: r = !z;
            3'h3: r = !s;
            3'h4: r = !o;
            3'h5: r = !((s ^ o) | z);
            default: r = !(s ^ o);
        endcase
        return r ^ cc[3];
    endfunction : cond_f
    task automatic look(bit_op_t op, int i, int bb, int cy);
        chk("dec_valid", {7'h0, dec_valid}, 8'h01);
        chk("opnd_kind", {4'h0, opnd_kind}, {4'h0, kt[i]});
        if (kt[i] == K_DREG) chk("reg_sel", {6'h0, reg_sel}, 8'(i));
        chk("instr_bytes", {4'h0, instr_bytes}, 8'(bb));
        chk("instr_cycles", {4'h0, instr_cycles}, 8'(cy));
        chk("size_word", {7'h0, size_word}, {7'h0, op == OP_INDEX && sz});
    endtask : look
    // ==========================================================
    // every operand field through every operation class except the carry form
    task automatic t_fields();
        bit_op_t op;
        for (int i = 0; i < 20; i++) begin
            automatic int e = ext(kt[i]);
            automatic logic r = (kt[i] == K_DREG) || (kt[i] == K_AREG);
            sz = i[0];
            drv(OP_NTEST, ft[i], i[1], 4'h0);
            look(OP_NTEST, i, 2 + e, r ? 1 : 3);
            chk("ntest carry", {7'h0, carry_out}, {7'h0, !i[1]});
            ce = !i[1];
            drv(OP_AND, ft[i], i[2], 4'h0);
            look(OP_AND, i, 3 + e, r ? 2 : 4);
            chk("and carry", {6'h0, carry_we, carry_out}, {6'h0, 1'b1, ce & i[2]});
            chk("and bit_we", {7'h0, bit_we}, 8'h00);
            ce = ce & i[2];
            drv(OP_XNOR, ft[i], i[3], 4'h0);
            look(OP_XNOR, i, 3 + e, r ? 2 : 4);
            chk("xnor carry", {7'h0, carry_out}, {7'h0, !(ce ^ i[3])});
            ce = !(ce ^ i[3]);
            drv(OP_OR, ft[i], i[4], 4'h0);
            look(OP_OR, i, 3 + e, r ? 2 : 4);
            chk("or carry", {7'h0, carry_out}, {7'h0, ce | i[4]});
            ce = ce | i[4];
            for (int k = 0; k < 2; k++) begin
                op = (k == 0) ? OP_NAND : OP_NOR;
                drv(op, ft[i], i[1], 4'h0);
                look(op, i, 3 + e, r ? 2 : 4);
                chk("comb we", {6'h0, carry_we, bit_we}, 8'h02);
                ex = (k == 0) ? (ce & !i[1]) : (ce | !i[1]);
                chk("nand nor carry", {7'h0, carry_out}, {7'h0, ex});
                ce = ex;
            end
            drv(OP_CLEAR, ft[i], 1'b1, 4'h0);
            look(OP_CLEAR, i, 2 + e, r ? 1 : 3);
            chk("clear bit", {6'h0, bit_we, bit_out}, 8'h02);
            drv(OP_INVERT, ft[i], i[1], 4'h0);
            look(OP_INVERT, i, 2 + e, r ? 1 : 3);
            chk("invert bit", {6'h0, bit_we, bit_out}, {6'h0, 1'b1, !i[1]});
            drv(OP_CBS_MEM, ft[i], 1'b0, 4'h3);
            look(OP_CBS_MEM, i, 3 + e, r ? 3 : 4);
            drv(OP_INDEX, ft[i], 1'b0, 4'h0);
            look(OP_INDEX, i, 2 + e, r ? 4 : ((i == 8 || i == 9) ? 3 : 6));
            // one idle cycle sits between the prefix and this instruction
            drv(OP_CLEAR, 5'h12, 1'b0, 4'h0);
            chk("after index", {4'h0, instr_cycles}, 8'h02);
        end
    endtask : t_fields
    // ==========================================================
    // every condition code against every flag combination, both forms
    task automatic t_cond();
        for (int v = 0; v < 16; v++) begin
            for (int c = 0; c < 16; c++) begin
                if (c[2:0] == 3'h7) continue;
                @(posedge core_clk);
                {zero_in, sign_in, ovf_in} <= v[2:0];
                drv(OP_NTEST, 5'h12, !v[3], 4'h0);
                ex = cond_f(4'(c), v[3], v[2], v[1], v[0]);
                drv(OP_CBS_MEM, 5'h10, 1'b0, 4'(c));
                chk("cbs bit", {6'h0, bit_we, bit_out}, {6'h0, 1'b1, ex});
                drv(OP_CBS_CARRY, 5'h00, 1'b0, 4'(c));
                chk("cbs carry", {6'h0, carry_we, carry_out}, {6'h0, 1'b1, ex});
                chk("cbs len", {instr_bytes, instr_cycles}, 8'h22);
            end
        end
    endtask : t_cond
    // ==========================================================
    // unused field code, then reset in mid-run with a prefix pending
    task automatic t_reset();
        drv(OP_AND, 5'h14, 1'b1, 4'h0);
        chk("unused kind", {opnd_kind, instr_bytes}, {K_BAD, BYTES_COMB_BASE});
        drv(OP_INDEX, 5'h12, 1'b0, 4'h0);
        @(posedge core_clk);
        arst_n <= 1'b0;
        #1;
        chk("reset out", {dec_valid, carry_we, bit_we, instr_cycles, 1'b0}, 8'h00);
        @(posedge core_clk);
        arst_n <= 1'b1;
        // reset must drop the pending prefix, so no extra cycle here
        drv(OP_CLEAR, 5'h12, 1'b0, 4'h0);
        chk("after reset", {4'h0, instr_cycles}, 8'h01);
    endtask : t_reset
    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : final_report
    // hang guard, generous against about 2000 cycles of traffic
    always @(posedge core_clk) begin
        cyc_cnt++;
        if (cyc_cnt == 20000) begin
            err_total++;
            final_report();
        end
    end
    initial begin
        repeat (2) @(posedge core_clk);
        arst_n <= 1'b1;
        #1;
        chk("idle out", {dec_valid, size_word, carry_we, bit_we, instr_bytes}, 8'h00);
        t_fields();
        t_cond();
        t_reset();
        final_report();
    end
endmodule : tb
`default_nettype wire
